// ===== spi_pkg.sv
// Constants, register map and state encoding of the master-only serial shift unit.
// Assumes one 20 MHz peripheral clock and the processor's special function register bus.

package spi_pkg;
    localparam logic [7:0] ADDR_DIVIDER = 8'hd2;
    localparam logic [7:0] ADDR_STATUS = 8'hd3;
    localparam logic [7:0] ADDR_TX_HOLD = 8'hd4;
    localparam logic [7:0] ADDR_RX_HOLD = 8'hd5;
    localparam logic [7:0] ADDR_CONTROL0 = 8'hd6;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'hd7;

    // Control register zero fields
    localparam int CTL_TX_ENABLE = 6;
    localparam int CTL_RE = 5;
    localparam int CTL_EN = 4;
    localparam int CTL_SSEL = 3;
    localparam int CTL_LSB = 2;
    localparam int CTL_POL = 1;
    localparam logic [7:0] CTL_MASK = 8'h7e;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Status and interrupt enable fields share bit positions
    localparam int FLG_RX_FULL = 0;
    localparam int FLG_TX_EMPTY = 1;
    localparam int FLG_OVERRUN = 2;
    localparam int FLG_TX_END = 3;
    localparam int FLG_BUSY = 4;
    localparam logic [3:0] FLAG_RESET = 4'h2;
    localparam logic [3:0] IE_RESET = 4'h0;

    localparam logic [7:0] DIV_MASK = 8'hfc;
    localparam logic [7:0] DIV_RESET = 8'h04;

    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SYNC_STAGES = 3;
    // Sample strobe trails the trailing edge by the synchroniser depth
    localparam int SAMPLE_DELAY = SYNC_STAGES;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_LEAD = 2'b01,
        XFER_SHIFT = 2'b10,
        XFER_TAIL = 2'b11
    } xfer_state_t;
endpackage

// ===== spi_clk_divider.sv
// Half-period tick generator for the serial clock.
// Assumes the divider value is stable while a byte is in flight.
`timescale 1ns/10ps
`default_nettype none

module spi_clk_divider
    import spi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] divider,
    output logic half_tick
);
    logic [6:0] cnt_reg;
    logic tick_reg;
    logic [6:0] half_len;
    logic at_end;

    // Divisor is a multiple of 4, so half a period is the masked value over 2, or 2 when the masked value is zero
    assign half_len = (divider[7:2] == 6'h00) ? 7'h02 : {divider[7:2], 1'b0};
    assign at_end = (cnt_reg == half_len - 7'h01);
    assign half_tick = tick_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !run) begin
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= at_end ? 7'h00 : cnt_reg + 7'h01;
            tick_reg <= at_end;
        end
    end

    chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (run && tick_reg) |=> !tick_reg)
        else $error("divider ticks closer than two cycles");
endmodule // spi_clk_divider

`default_nettype wire

// ===== spi_master_shift_unit.sv
// Master-only serial shift unit behind the special function register bus.
// Assumes single-cycle register strobes on ref_clk and an asynchronous serial input pin.
`timescale 1ns/10ps
`default_nettype none

module spi_master_shift_unit
    import spi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic spi_irq,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_clock_pin,
    output logic target_select_pin_n
);
    xfer_state_t state_reg;
    xfer_state_t state_next;

    logic [7:0] ctrl_reg;
    logic [3:0] ie_reg;
    logic [7:0] div_reg;
    logic [3:0] flag_reg;
    logic [3:0] flag_next;
    logic [7:0] tx_hold_reg;
    logic tx_full_reg;
    logic [7:0] rx_hold_reg;
    logic rx_full_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] rx_cnt_reg;
    logic phase_reg;
    logic [SAMPLE_DELAY-1:0] samp_pipe_reg;
    logic sclk_reg;
    logic sout_reg;
    logic sel_n_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic rx_bit_reg;

    // Decoding
    logic wr_ctrl;
    logic wr_ie;
    logic wr_div;
    logic wr_tx;
    logic rd_status;
    logic rd_rx;
    assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONTROL0);
    assign wr_ie = sfr_wr && (sfr_addr == ADDR_INT_ENABLE);
    assign wr_div = sfr_wr && (sfr_addr == ADDR_DIVIDER);
    assign wr_tx = sfr_wr && (sfr_addr == ADDR_TX_HOLD);
    assign rd_status = sfr_rd && (sfr_addr == ADDR_STATUS);
    assign rd_rx = sfr_rd && (sfr_addr == ADDR_RX_HOLD);

    logic transmitter_enable_bit;
    logic re;
    logic pol;
    logic lsb_first;
    logic ssel;
    logic enabled;
    assign transmitter_enable_bit = ctrl_reg[CTL_TX_ENABLE];
    assign re = ctrl_reg[CTL_RE];
    assign pol = ctrl_reg[CTL_POL];
    assign lsb_first = ctrl_reg[CTL_LSB];
    assign ssel = ctrl_reg[CTL_SSEL];
    assign enabled = transmitter_enable_bit && ctrl_reg[CTL_EN];

    logic busy;
    assign busy = (state_reg != XFER_IDLE);

    // Bit timing
    logic half_tick;
    spi_clk_divider u_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(busy && enabled),
        .divider(div_reg),
        .half_tick(half_tick)
    );

    logic start;
    logic lead_edge;
    logic trail_edge;
    logic sample_now;
    logic abort;
    logic frame_done;
    assign start = (state_reg == XFER_IDLE) && enabled && tx_full_reg;
    assign lead_edge = (state_reg == XFER_SHIFT) && half_tick && !phase_reg;
    assign trail_edge = (state_reg == XFER_SHIFT) && half_tick && phase_reg;
    assign sample_now = samp_pipe_reg[SAMPLE_DELAY-1];
    assign abort = busy && !enabled;
    assign frame_done = (state_reg == XFER_TAIL) && sample_now && (rx_cnt_reg == LAST_BIT);

    // Outgoing bit and incoming byte, both steered by bit order
    logic out_bit;
    logic [7:0] tx_sh_shifted;
    logic [7:0] rx_byte;
    assign out_bit = lsb_first ? tx_sh_reg[0] : tx_sh_reg[BYTE_BITS-1];
    assign tx_sh_shifted = lsb_first ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
    assign rx_byte = lsb_first ? {rx_bit_reg, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], rx_bit_reg};

    logic rx_store;
    assign rx_store = frame_done && re;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            XFER_IDLE: begin
                if (start) begin
                    state_next = XFER_LEAD;
                end
            end
            XFER_LEAD: begin
                if (half_tick) begin
                    state_next = XFER_SHIFT;
                end
            end
            XFER_SHIFT: begin
                if (trail_edge && bit_cnt_reg == LAST_BIT) begin
                    state_next = XFER_TAIL;
                end
            end
            XFER_TAIL: begin
                if (frame_done) begin
                    state_next = XFER_IDLE;
                end
            end
            default: begin
                state_next = XFER_IDLE;
            end
        endcase
        if (abort) begin
            state_next = XFER_IDLE;
        end
    end

    // Hardware set wins over the clear-on-read
    always_comb begin
        flag_next = rd_status ? 4'h0 : flag_reg;
        if (start) begin
            flag_next[FLG_TX_EMPTY] = 1'b1;
        end
        if (rx_store) begin
            flag_next[FLG_RX_FULL] = 1'b1;
        end
        if (rx_store && rx_full_reg && !rd_rx) begin
            flag_next[FLG_OVERRUN] = 1'b1;
        end
        if (frame_done) begin
            flag_next[FLG_TX_END] = 1'b1;
        end
    end

    logic [7:0] rd_mux;
    assign rd_mux = (sfr_addr == ADDR_CONTROL0) ? ctrl_reg :
                    (sfr_addr == ADDR_INT_ENABLE) ? {4'h0, ie_reg} :
                    (sfr_addr == ADDR_DIVIDER) ? div_reg :
                    (sfr_addr == ADDR_STATUS) ? {3'h0, busy, flag_reg} :
                    (sfr_addr == ADDR_RX_HOLD) ? rx_hold_reg : 8'h00;

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg <= CTL_RESET;
            ie_reg <= IE_RESET;
            div_reg <= DIV_RESET;
            flag_reg <= FLAG_RESET;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= sfr_wdata & CTL_MASK;
            end
            if (wr_ie) begin
                ie_reg <= sfr_wdata[3:0];
            end
            if (wr_div) begin
                div_reg <= sfr_wdata & DIV_MASK;
            end
            flag_reg <= flag_next;
            irq_reg <= |(flag_next & ie_reg);
            if (sfr_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Double buffers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_hold_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            rx_hold_reg <= 8'h00;
            rx_full_reg <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_hold_reg <= sfr_wdata;
            end
            tx_full_reg <= wr_tx || (tx_full_reg && !start);
            if (rx_store) begin
                rx_hold_reg <= rx_byte;
            end
            rx_full_reg <= rx_store || (rx_full_reg && !rd_rx);
        end
    end

    // Serial input synchroniser; a change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            rx_bit_reg <= 1'b0;
        end else begin
            sync1_reg <= serial_in_pin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                rx_bit_reg <= sync3_reg;
            end
        end
    end

    // Shift engine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= XFER_IDLE;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            rx_cnt_reg <= 3'h0;
            phase_reg <= 1'b0;
            samp_pipe_reg <= '0;
            sclk_reg <= 1'b0;
            sout_reg <= 1'b0;
            sel_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            samp_pipe_reg <= abort ? '0 : {samp_pipe_reg[SAMPLE_DELAY-2:0], trail_edge};
            if (start) begin
                tx_sh_reg <= tx_hold_reg;
                bit_cnt_reg <= 3'h0;
                rx_cnt_reg <= 3'h0;
                phase_reg <= 1'b0;
                sel_n_reg <= !ssel;
            end
            if (lead_edge) begin
                sclk_reg <= !pol;
                sout_reg <= out_bit;
                tx_sh_reg <= tx_sh_shifted;
                phase_reg <= 1'b1;
            end
            if (trail_edge) begin
                sclk_reg <= pol;
                phase_reg <= 1'b0;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (sample_now) begin
                rx_sh_reg <= rx_byte;
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
            if (frame_done || abort) begin
                sel_n_reg <= 1'b1;
            end
            if (state_reg == XFER_IDLE || abort) begin
                sclk_reg <= pol;
            end
        end
    end

    assign sfr_rdata = rdata_reg;
    assign spi_irq = irq_reg;
    assign serial_out_pin = sout_reg;
    assign serial_clock_pin = sclk_reg;
    assign target_select_pin_n = sel_n_reg;

    // Lead edges counted apart from the shift counter, so a miscounted byte shows up
    logic [3:0] lead_seen_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || start) begin
            lead_seen_reg <= 4'h0;
        end else if (lead_edge) begin
            lead_seen_reg <= lead_seen_reg + 4'h1;
        end
    end

    chk_idle_clock_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!transmitter_enable_bit && $stable(ctrl_reg)) |=> (serial_clock_pin == pol))
        else $error("serial clock not idle while transmitter disabled");

    chk_busy_on_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && !wr_tx) |=> (busy && !tx_full_reg))
        else $error("busy not raised at byte start");

    chk_select_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && ssel) |=> !target_select_pin_n throughout (busy [*2]))
        else $error("target select not low during byte");

    chk_select_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (frame_done || abort) |=> target_select_pin_n)
        else $error("target select still low after byte");

    chk_eight_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        frame_done |-> (lead_seen_reg == 4'(BYTE_BITS)))
        else $error("byte ended with wrong bit count");

    chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_status && rx_store) |=> flag_reg[FLG_RX_FULL])
        else $error("receive flag lost on status read");

    chk_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_status && !start && !rx_store && !frame_done) |=> (flag_reg == 4'h0))
        else $error("status read did not clear flags");

    chk_div_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> (div_reg == DIV_RESET))
        else $error("divider not reset to divide by four");

    chk_lead_edge_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (lead_edge && !abort) |=> (serial_clock_pin == !pol) && (serial_out_pin == $past(out_bit)))
        else $error("leading edge did not drive clock and data");

    chk_tx_empty_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start |=> flag_reg[FLG_TX_EMPTY])
        else $error("transmit empty flag not set at load");

    chk_idle_stops: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (frame_done && !tx_full_reg && !wr_tx) |=> (state_reg == XFER_IDLE) [*2])
        else $error("clock kept running with empty transmit buffer");

    chk_rx_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_rx |=> (sfr_rdata == $past(rx_hold_reg)))
        else $error("receive holding read returned wrong byte");
endmodule // spi_master_shift_unit

`default_nettype wire

// ===== spi_target_model.sv
// Behavioural serial target facing the master shift unit.
// Assumes the serial clock stands at its polarity level between frames.
`timescale 1ns/10ps
`default_nettype none

module spi_target_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic pol,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output int nbytes
);
    int leads = 0;
    int trails = 0;
    logic [7:0] sh;

    initial miso = 1'b0;
    initial nbytes = 0;

    always @(sclk) begin
        if (sclk !== pol) begin
            // Leading edge: a frame starts on its first clock edge, select or not
            if (leads % 8 == 0) begin
                sh = tx_byte ^ nbytes[7:0];
            end
            miso = lsb ? sh[leads % 8] : sh[7 - leads % 8];
            leads++;
        end else if (trails < leads) begin
            // Guard: a polarity change at idle is not a trailing edge
            rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            trails++;
            if (trails % 8 == 0) begin
                nbytes++;
                // Released line keeps no value; show the inverse after the hold time
                miso <= #175 ~miso;
            end
        end
    end
endmodule // spi_target_model
`default_nettype wire

// ===== spi_master_shift_unit_test.sv
// Self-checking bench for the master-only serial shift unit.
// Assumes spi_target_model on the far side; divisors of 8 and up give the target hold time.
`timescale 1ns/10ps
`default_nettype none

module spi_master_shift_unit_test;
    import spi_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic spi_irq;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_clock_pin;
    logic target_select_pin_n;
    logic pol = 1'b0;
    logic lsb = 1'b0;
    logic ssel = 1'b0;
    logic [7:0] tgt_tx = 8'h00;
    logic [7:0] tgt_rx;
    int tgt_n;
    int err_total = 0;
    int checks = 0;
    int seed = 32'h449d;
    int div = 4;
    int nlead = 0;
    int frames = 0;
    real t_lead = 0.0;
    logic [7:0] sent_q[$];

    always #25 ref_clk = ~ref_clk;

    spi_master_shift_unit u_spi_master_shift_unit (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .spi_irq(spi_irq), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_clock_pin(serial_clock_pin),
        .target_select_pin_n(target_select_pin_n)
    );

    spi_target_model u_spi_target_model (
        .sclk(serial_clock_pin), .mosi(serial_out_pin), .pol(pol), .lsb(lsb),
        .tx_byte(tgt_tx), .miso(serial_in_pin), .rx_byte(tgt_rx), .nbytes(tgt_n)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask

    // Read data is sampled one edge late; it holds until the next read anyway
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(posedge ref_clk);
        #1 chk(32'(sfr_rdata), 32'(exp), what);
    endtask

    task automatic xfer(input int nb);
        logic [7:0] d;
        int i;
        for (i = 0; i < nb; i++) begin
            d = 8'($random(seed));
            sent_q.push_back(d);
            wr(ADDR_TX_HOLD, d);
            if (i == 0) begin
                rchk(ADDR_STATUS, 8'h12, "busy");
            end
        end
        frames += nb;
        for (i = 0; i < 40000 && tgt_n < frames; i++) begin
            @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
        chk(32'(tgt_n), 32'(frames), "frames");
        chk(32'(target_select_pin_n), 32'h1, "deselect");
        chk(32'(nlead), 32'(8 * frames), "edges");
        chk(32'(spi_irq), 32'h1, "irq");
        rchk(ADDR_STATUS, nb > 1 ? 8'h0f : 8'h09, "flags");
        rchk(ADDR_RX_HOLD, tgt_tx ^ 8'(frames - 1), "rx");
        rchk(ADDR_STATUS, 8'h00, "cleared");
        chk(32'(spi_irq), 32'h0, "irq_off");
        chk(32'(serial_clock_pin), 32'(pol), "idle");
    endtask

    always @(serial_clock_pin) begin
        if (rst_n === 1'b1 && serial_clock_pin !== pol) begin
            if (nlead % 8 != 0) begin
                chk(32'($rtoi($realtime - t_lead)), 32'(div * 50), "period");
            end
            chk(32'(target_select_pin_n), 32'(!ssel), "select");
            t_lead = $realtime;
            nlead++;
        end
    end

    always @(tgt_n) begin
        if (tgt_n > 0) begin
            chk(32'(tgt_rx), 32'(sent_q.pop_front()), "mosi");
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(ADDR_DIVIDER, DIV_RESET, "div_reset");
        rchk(ADDR_STATUS, 8'h02, "status_reset");
        rchk(ADDR_CONTROL0, 8'h00, "control_reset");
        rchk(ADDR_TX_HOLD, 8'h00, "tx_read");
        rchk(8'hd0, 8'h00, "unmapped");
        wr(ADDR_RX_HOLD, 8'ha5);
        rchk(ADDR_RX_HOLD, 8'h00, "rx_write");
        wr(ADDR_INT_ENABLE, 8'hff);
        rchk(ADDR_INT_ENABLE, 8'h0f, "enable_mask");
        for (int k = 0; k < 6; k++) begin
            pol = k[0];
            lsb = k[1];
            ssel = (k != 4);
            div = k == 0 ? 36 : (($random(seed) & 32'hfc) | 8);
            tgt_tx = 8'($random(seed));
            wr(ADDR_DIVIDER, 8'(div) | 8'h03);
            rchk(ADDR_DIVIDER, 8'(div), "divider");
            wr(ADDR_CONTROL0, {4'b0111, ssel, lsb, pol, 1'b1});
            rchk(ADDR_CONTROL0, {4'b0111, ssel, lsb, pol, 1'b0}, "control");
            xfer(k > 3 ? 2 : 1);
        end
        // Clearing the transmitter during the lead-in must drop the byte quietly
        wr(ADDR_TX_HOLD, 8'($random(seed)));
        wr(ADDR_CONTROL0, {4'b0011, ssel, lsb, pol, 1'b0});
        rchk(ADDR_STATUS, 8'h02, "abort_status");
        chk(32'(serial_clock_pin), 32'(pol), "abort_idle");
        chk(32'(target_select_pin_n), 32'h1, "abort_select");
        chk(32'(nlead), 32'(8 * frames), "abort_edges");
        report_and_stop();
    end

    // Longest run is well under a millisecond of simulated time
    initial begin
        #3_000_000;
        err_total++;
        report_and_stop();
    end
endmodule // spi_master_shift_unit_test
`default_nettype wire
